// file: cst_bus_port.sv
`timescale 1ns/10ps
// AHB-Lite front end: one wait state on every transfer
module cst_bus_port #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // AHB-Lite address phase
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  // Register access strobes, valid in the first data cycle
  output logic                   acc_wr_o,
  output logic                   acc_rd_o,
  output logic [ADDR_W-1:0]      acc_addr_o
);

  logic              pend_ff;  // Data phase in its first cycle
  logic              wr_ff;    // Captured direction
  logic [ADDR_W-1:0] addr_ff;  // Captured address
  logic              rdy_ff;   // Ready toward the bus
  logic              accept;   // Address phase taken this edge

  // NONSEQ or SEQ both count; the master only issues NONSEQ
  assign accept = hsel_i & htrans_i[1] & hready_i;

  // Capture the address phase
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ff   <= 1'b0;
      addr_ff <= '0;
    end else if (accept) begin
      wr_ff   <= hwrite_i;
      addr_ff <= haddr_i;
    end
  end

  // One wait cycle gives the read data time to land in a flop
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_ff <= 1'b0;
      rdy_ff  <= 1'b1;
    end else begin
      pend_ff <= accept;
      rdy_ff  <= ~accept;
    end
  end

  assign hreadyout_o = rdy_ff;
  assign acc_wr_o    = pend_ff & wr_ff;
  assign acc_rd_o    = pend_ff & ~wr_ff;
  assign acc_addr_o  = addr_ff;

  // Taken transfer: exactly one low cycle, then ready
  sequence s_one_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_bus_wait_state: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    accept |=> s_one_wait)
    else $error("Transfer did not get exactly one wait state");

endmodule

// file: cst_pkg.sv
package cst_pkg;

  // Register width and field sizes
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LVL_W  = 3;
  localparam int unsigned FLAG_W = 4;
  localparam int unsigned EV_W   = 3;

  // Byte offsets on the register bus
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_CORE    = 8'h04;
  localparam logic [7:0] OFF_INTCTL  = 8'h08;
  localparam logic [7:0] OFF_EV_STAT = 8'h0c;
  localparam logic [7:0] OFF_EV_CLR  = 8'h10;
  localparam logic [7:0] OFF_EV_EN   = 8'h14;

  // Status word field positions
  localparam int unsigned STW_CARRY  = 0;
  localparam int unsigned STW_ZERO   = 1;
  localparam int unsigned STW_WRAP   = 2;
  localparam int unsigned STW_NEG    = 3;
  localparam int unsigned STW_REPEAT = 4;
  localparam int unsigned STW_LVL_LO = 5;
  localparam int unsigned STW_LVL_HI = 7;
  localparam int unsigned STW_CLIP_ANY = 10;
  localparam int unsigned STW_CLIP_B = 12;
  localparam int unsigned STW_CLIP_A = 13;

  // Core control word: level msb position, other bits that hold data
  localparam int unsigned CCW_LVL_MSB = 3;
  localparam logic [15:0] CCW_WR_MASK = 16'hbff3;

  // Interrupt control one: nesting disable position
  localparam int unsigned ICW_NEST_DIS = 15;

  // Event bit positions
  localparam int unsigned EV_CLIP_A = 0;
  localparam int unsigned EV_CLIP_B = 1;
  localparam int unsigned EV_WRAP   = 2;

  // Reset values
  localparam logic [2:0]  LVL_RST   = 3'h0;
  localparam logic [3:0]  FLAG_RST  = 4'h0;
  localparam logic [15:0] CCW_RST   = 16'h0000;
  localparam logic [2:0]  EV_RST    = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Level at which user interrupts are shut out
  localparam logic [2:0] LVL_MAX = 3'h7;

endpackage

// file: cst_status_flags.sv
`timescale 1ns/10ps
module cst_status_flags #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // AHB-Lite slave
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // Execute stage results
  input  wire logic              ex_done_i,
  input  wire logic [3:0]        flag_affect_i,
  input  wire logic              res_neg_i,
  input  wire logic              res_wrap_i,
  input  wire logic              res_zero_i,
  input  wire logic              res_carry_i,
  input  wire logic              zero_keep_i,
  // Core state
  input  wire logic              repeat_busy_i,
  input  wire logic              level_load_i,
  input  wire logic [3:0]        level_val_i,
  input  wire logic              clip_a_i,
  input  wire logic              clip_b_i,
  // Priority and interrupt outputs
  output logic [3:0]             cpu_priority_level_o,
  output logic                   user_irq_block_o,
  output logic                   irq_o
);

  // Refuse address widths that cannot hold the map
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must lie between 8 and 32");
  end

  // Bus side
  logic              acc_wr;      // Write strobe, first data cycle
  logic              acc_rd;      // Read strobe, first data cycle
  logic [ADDR_W-1:0] acc_addr;    // Captured address
  logic [15:0]       wdata;       // Low half of the write data
  logic              stw_wr;      // Write to the status word
  logic              ccw_wr;      // Write to the core control word

  // Status word contents
  logic [2:0]        lvl_ff;              // Low three level bits
  logic [3:0]        flags_ff;            // Neg, wrap, zero, carry
  logic [3:0]        nxt_flags;
  logic              repeat_active_flag_ff; // Repeat loop running
  logic              clip_a_ff;           // Accumulator A clip sticky
  logic              clip_b_ff;           // Accumulator B clip sticky
  logic              nxt_clip_a;
  logic              nxt_clip_b;

  // Control words
  logic [15:0]       ccw_ff;              // Core control word
  logic              nest_dis_ff;         // Nesting disable

  // Events
  logic [2:0]        ev_stat_ff;          // Sticky event bits
  logic [2:0]        ev_en_ff;            // Event enables
  logic [2:0]        ev_set;              // Events this cycle
  logic [2:0]        ev_clr;              // Clear request this cycle

  // Output flops
  logic [31:0]       hrdata_ff;
  logic              hresp_ff;
  logic [3:0]        level_ff;
  logic              block_ff;
  logic              irq_ff;

  // Address compare shared by every decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  // Status word as software reads it; absent upper bits read zero
  function automatic logic [15:0] stw_view(input logic [2:0] lvl, input logic rep,
                                           input logic [3:0] fl, input logic ca,
                                           input logic cb);
    return {2'b00, ca, cb, 1'b0, ca | cb, 2'b00, lvl, rep, fl};
  endfunction

  cst_bus_port #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .acc_wr_o    (acc_wr),
    .acc_rd_o    (acc_rd),
    .acc_addr_o  (acc_addr)
  );

  assign wdata  = hwdata_i[15:0];
  assign stw_wr = acc_wr & reg_hit(acc_addr, cst_pkg::OFF_STATUS);
  assign ccw_wr = acc_wr & reg_hit(acc_addr, cst_pkg::OFF_CORE);

  // Level field: core load wins, software only while nesting enabled
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lvl_ff <= cst_pkg::LVL_RST;
    end else if (level_load_i) begin
      lvl_ff <= level_val_i[2:0];
    end else if (stw_wr && !nest_dis_ff) begin
      lvl_ff <= wdata[cst_pkg::STW_LVL_HI:cst_pkg::STW_LVL_LO];
    end
  end

  // Condition flags; the execute stage wins over a same-cycle write
  always_comb begin
    nxt_flags = flags_ff;
    if (stw_wr) begin
      nxt_flags = wdata[3:0];
    end
    if (ex_done_i) begin
      if (flag_affect_i[cst_pkg::STW_NEG]) begin
        nxt_flags[cst_pkg::STW_NEG] = res_neg_i;
      end
      if (flag_affect_i[cst_pkg::STW_WRAP]) begin
        nxt_flags[cst_pkg::STW_WRAP] = res_wrap_i;
      end
      if (flag_affect_i[cst_pkg::STW_ZERO]) begin
        // Extended-precision ops only ever clear it
        if (!res_zero_i) begin
          nxt_flags[cst_pkg::STW_ZERO] = 1'b0;
        end else if (!zero_keep_i) begin
          nxt_flags[cst_pkg::STW_ZERO] = 1'b1;
        end
      end
      if (flag_affect_i[cst_pkg::STW_CARRY]) begin
        nxt_flags[cst_pkg::STW_CARRY] = res_carry_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flags_ff <= cst_pkg::FLAG_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Repeat loop status follows the sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      repeat_active_flag_ff <= 1'b0;
    end else begin
      repeat_active_flag_ff <= repeat_busy_i;
    end
  end

  // Clip stickies: combined bit written low clears both
  always_comb begin
    nxt_clip_a = clip_a_ff;
    nxt_clip_b = clip_b_ff;
    if (stw_wr) begin
      if (!wdata[cst_pkg::STW_CLIP_ANY]) begin
        nxt_clip_a = 1'b0;
        nxt_clip_b = 1'b0;
      end else begin
        nxt_clip_a = wdata[cst_pkg::STW_CLIP_A];
        nxt_clip_b = wdata[cst_pkg::STW_CLIP_B];
      end
    end
    // Saturation in the same cycle beats the write, so no event is lost
    if (clip_a_i) begin
      nxt_clip_a = 1'b1;
    end
    if (clip_b_i) begin
      nxt_clip_b = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      clip_a_ff <= 1'b0;
      clip_b_ff <= 1'b0;
    end else begin
      clip_a_ff <= nxt_clip_a;
      clip_b_ff <= nxt_clip_b;
    end
  end

  // Core control word; level msb is clear-only for software
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ccw_ff <= cst_pkg::CCW_RST;
    end else begin
      if (ccw_wr) begin
        ccw_ff <= wdata & cst_pkg::CCW_WR_MASK;
        ccw_ff[cst_pkg::CCW_LVL_MSB] <= ccw_ff[cst_pkg::CCW_LVL_MSB]
                                        & wdata[cst_pkg::CCW_LVL_MSB];
      end
      if (level_load_i) begin
        ccw_ff[cst_pkg::CCW_LVL_MSB] <= level_val_i[3];
      end
    end
  end

  // Interrupt control one: only the nesting disable is held here
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      nest_dis_ff <= 1'b0;
    end else if (acc_wr && reg_hit(acc_addr, cst_pkg::OFF_INTCTL)) begin
      nest_dis_ff <= hwdata_i[cst_pkg::ICW_NEST_DIS];
    end
  end

  // Event sources and write-one-to-clear requests
  assign ev_set = {ex_done_i & flag_affect_i[cst_pkg::STW_WRAP] & res_wrap_i,
                   clip_b_i, clip_a_i};
  assign ev_clr = (acc_wr && reg_hit(acc_addr, cst_pkg::OFF_EV_CLR)) ? hwdata_i[2:0] : 3'h0;

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ev_stat_ff <= cst_pkg::EV_RST;
    end else begin
      ev_stat_ff <= (ev_stat_ff & ~ev_clr) | ev_set;
    end
  end

  // Event enables
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ev_en_ff <= cst_pkg::EV_RST;
    end else if (acc_wr && reg_hit(acc_addr, cst_pkg::OFF_EV_EN)) begin
      ev_en_ff <= hwdata_i[2:0];
    end
  end

  // Read data lands during the wait cycle; unmapped reads give zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hrdata_ff <= cst_pkg::RDATA_RST;
    end else if (acc_rd) begin
      hrdata_ff <= cst_pkg::RDATA_RST;
      if (reg_hit(acc_addr, cst_pkg::OFF_STATUS)) begin
        hrdata_ff[15:0] <= stw_view(lvl_ff, repeat_active_flag_ff, flags_ff,
                                    clip_a_ff, clip_b_ff);
      end else if (reg_hit(acc_addr, cst_pkg::OFF_CORE)) begin
        hrdata_ff[15:0] <= ccw_ff;
      end else if (reg_hit(acc_addr, cst_pkg::OFF_INTCTL)) begin
        hrdata_ff[cst_pkg::ICW_NEST_DIS] <= nest_dis_ff;
      end else if (reg_hit(acc_addr, cst_pkg::OFF_EV_STAT)) begin
        hrdata_ff[2:0] <= ev_stat_ff;
      end else if (reg_hit(acc_addr, cst_pkg::OFF_EV_EN)) begin
        hrdata_ff[2:0] <= ev_en_ff;
      end
    end
  end

  // Response is always OKAY
  always_ff @(posedge mclk_i) begin
    hresp_ff <= 1'b0;
  end

  // Level and block outputs lag the register by one cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      level_ff <= 4'h0;
      block_ff <= 1'b0;
    end else begin
      level_ff <= {ccw_ff[cst_pkg::CCW_LVL_MSB], lvl_ff};
      block_ff <= (lvl_ff == cst_pkg::LVL_MAX) | ccw_ff[cst_pkg::CCW_LVL_MSB];
    end
  end

  // Interrupt line from enabled sticky events
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(ev_stat_ff & ev_en_ff);
    end
  end

  assign hrdata_o             = hrdata_ff;
  assign hresp_o              = hresp_ff;
  assign cpu_priority_level_o = level_ff;
  assign user_irq_block_o     = block_ff;
  assign irq_o                = irq_ff;

  default clocking cb_main @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_block_at_seven: assert property (
    (lvl_ff == 3'h7) |=> user_irq_block_o)
    else $error("Level seven did not block user interrupts");
  a_level_formed: assert property (
    ##1 cpu_priority_level_o == $past({ccw_ff[3], lvl_ff}))
    else $error("Priority level not formed from msb and field");
  a_msb_blocks_all: assert property (
    ccw_ff[3] |=> user_irq_block_o)
    else $error("Level msb did not block user interrupts");
  a_block_release: assert property (
    (lvl_ff != 3'h7 && !ccw_ff[3]) |=> !user_irq_block_o)
    else $error("User interrupts blocked below level seven");
  a_level_locked: assert property (
    (stw_wr && nest_dis_ff && !level_load_i) |=> $stable(lvl_ff))
    else $error("Level field changed while nesting disabled");
  a_repeat_tracks: assert property (
    repeat_busy_i ##1 repeat_busy_i |-> repeat_active_flag_ff ##1 repeat_active_flag_ff)
    else $error("Repeat flag did not follow the loop");
  a_neg_follows: assert property (
    (ex_done_i && flag_affect_i[3]) |=> flags_ff[3] == $past(res_neg_i))
    else $error("Negative flag not taken from result");
  a_wrap_follows: assert property (
    (ex_done_i && flag_affect_i[2]) |=> flags_ff[2] == $past(res_wrap_i)
                                        && ev_stat_ff[2] == ($past(res_wrap_i)
                                        || $past(ev_stat_ff[2] && !ev_clr[2])))
    else $error("Wrap flag or wrap event wrong");
  a_zero_sticky: assert property (
    (ex_done_i && flag_affect_i[1] && zero_keep_i && res_zero_i && !stw_wr)
    |=> $stable(flags_ff[1]))
    else $error("Sticky zero flag changed on zero result");
  a_carry_follows: assert property (
    (ex_done_i && flag_affect_i[0]) |=> flags_ff[0] == $past(res_carry_i))
    else $error("Carry flag not taken from result");
  a_clip_clear: assert property (
    (stw_wr && !wdata[10] && !clip_a_i && !clip_b_i) |=> !clip_a_ff && !clip_b_ff)
    else $error("Combined clip clear did not clear both");
  a_flag_hold: assert property (
    (!stw_wr && (!ex_done_i || !flag_affect_i[0])) |=> $stable(flags_ff[0]))
    else $error("Carry changed without an affecting operation");

endmodule

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // Clock and reset
  logic        mclk_i        = 1'b0;
  logic        sys_rst_i     = 1'b1;
  // Register bus
  logic        hsel_i        = 1'b0;
  logic [7:0]  haddr_i       = 8'h00;
  logic [1:0]  htrans_i      = 2'h0;
  logic        hwrite_i      = 1'b0;
  logic [31:0] hwdata_i      = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  // Execute and core side
  logic        ex_done_i     = 1'b0;
  logic [3:0]  flag_affect_i = 4'h0;
  logic        res_neg_i     = 1'b0;
  logic        res_wrap_i    = 1'b0;
  logic        res_zero_i    = 1'b0;
  logic        res_carry_i   = 1'b0;
  logic        zero_keep_i   = 1'b0;
  logic        repeat_busy_i = 1'b0;
  logic        level_load_i  = 1'b0;
  logic [3:0]  level_val_i   = 4'h0;
  logic        clip_a_i      = 1'b0;
  logic        clip_b_i      = 1'b0;
  logic [3:0]  cpu_priority_level_o;
  logic        user_irq_block_o;
  logic        irq_o;
  // Bench state
  typedef struct {string nm; logic [31:0] v;} cst_exp_type;
  cst_exp_type exp_q[$];       // Expected results, oldest first
  logic        rd_ph = 1'b0;   // Read data phase in flight
  logic        snap  = 1'b0;   // Port snapshot request
  logic [31:0] seed  = 32'd79837;
  logic [3:0]  fl;             // Model of the flag nibble
  logic [2:0]  evx;            // Model of event status
  int          fail_count      = 0;
  int          samples_checked = 0;

  // Free running 125 MHz clock
  always #4 mclk_i = ~mclk_i;

  cst_status_flags DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .ex_done_i(ex_done_i), .flag_affect_i(flag_affect_i), .res_neg_i(res_neg_i),
    .res_wrap_i(res_wrap_i), .res_zero_i(res_zero_i), .res_carry_i(res_carry_i),
    .zero_keep_i(zero_keep_i), .repeat_busy_i(repeat_busy_i), .level_load_i(level_load_i),
    .level_val_i(level_val_i), .clip_a_i(clip_a_i), .clip_b_i(clip_b_i),
    .cpu_priority_level_o(cpu_priority_level_o), .user_irq_block_o(user_irq_block_o),
    .irq_o(irq_o)
  );

  // Fibonacci style step, fixed start keeps runs repeatable
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Single comparison point
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Oldest note against what just appeared
  task automatic take(input logic [31:0] seen);
    cst_exp_type x;
    if (exp_q.size() == 0) begin
      chk("unexpected result", seen, 32'hffff_ffff);
    end else begin
      x = exp_q.pop_front();
      chk(x.nm, seen, x.v);
    end
  endtask

  // Watcher: read data at the completing edge, ports on request
  always @(posedge mclk_i) begin
    if (rd_ph && hreadyout_o === 1'b1) begin
      take(hrdata_o);
      chk("hresp", {31'h0, hresp_o}, 32'h0);
    end
    if (snap)
      take({29'h0, irq_o, user_irq_block_o, 1'b0} << 3 | {28'h0, cpu_priority_level_o});
  end

  // One AHB-Lite single transfer; waits on ready, only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do begin
      @(posedge mclk_i);
    end while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rd_ph    <= !wr;
    do begin
      @(posedge mclk_i);
    end while (hreadyout_o !== 1'b1);
    rd_ph    <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Read with its expectation noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back('{nm, e});
    bus(1'b0, a, 32'h0);
  endtask

  // Port snapshot {irq, block, level} after the two-cycle lag settles
  task automatic sn(input logic [5:0] e, input string nm);
    repeat (3) @(posedge mclk_i);
    exp_q.push_back('{nm, {26'h0, e}});
    snap <= 1'b1;
    @(posedge mclk_i);
    snap <= 1'b0;
  endtask

  // One execute-cycle completion; idle edge after so strobes never merge
  task automatic ex(input logic [3:0] f, input logic [3:0] r, input logic keep);
    ex_done_i     <= 1'b1;
    flag_affect_i <= f;
    {res_neg_i, res_wrap_i, res_zero_i, res_carry_i} <= r;
    zero_keep_i   <= keep;
    @(posedge mclk_i);
    ex_done_i     <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Timeout well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  // Main sequence
  initial begin
    evx = 3'h0;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(cst_pkg::OFF_STATUS, 32'h0, "status reset");
    rd(cst_pkg::OFF_CORE, 32'h0, "core reset");
    sn(6'h00, "ports reset");
    $display("test reset done");
    // Random results, every flag affected
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      ex(4'hf, seed[3:0], 1'b0);
      fl = seed[3:0];
      evx = evx | {seed[2], 2'b00};
      rd(cst_pkg::OFF_STATUS, {28'h0, fl}, "flags");
    end
    ex(4'h8, ~fl, 1'b0);
    fl[3] = ~fl[3];
    rd(cst_pkg::OFF_STATUS, {28'h0, fl}, "partial affect");
    ex(4'h2, 4'h2, 1'b0);
    rd(cst_pkg::OFF_STATUS, {28'h0, fl | 4'h2}, "zero set");
    ex(4'h2, 4'h2, 1'b1);
    rd(cst_pkg::OFF_STATUS, {28'h0, fl | 4'h2}, "zero held");
    ex(4'h2, 4'h0, 1'b1);
    rd(cst_pkg::OFF_STATUS, {28'h0, fl & 4'hd}, "zero cleared");
    ex(4'h2, 4'h2, 1'b1);
    rd(cst_pkg::OFF_STATUS, {28'h0, fl & 4'hd}, "zero stays clear");
    rd(cst_pkg::OFF_EV_STAT, {29'h0, evx}, "wrap events");
    $display("test flags done");
    // Level field and the all-ones block
    wr(cst_pkg::OFF_STATUS, 32'h0000_00e0);
    rd(cst_pkg::OFF_STATUS, 32'h0000_00e0, "level seven");
    sn(6'h17, "level seven block");
    wr(cst_pkg::OFF_STATUS, 32'h0000_0060);
    sn(6'h03, "level three open");
    level_val_i  <= 4'hb;
    level_load_i <= 1'b1;
    @(posedge mclk_i);
    level_load_i <= 1'b0;
    sn(6'h1b, "level eleven block");
    rd(cst_pkg::OFF_CORE, 32'h0000_0008, "core msb");
    rd(cst_pkg::OFF_STATUS, 32'h0000_0060, "low level bits");
    wr(cst_pkg::OFF_CORE, 32'h0000_0000);
    sn(6'h03, "msb cleared");
    $display("test level done");
    // Nesting disable freezes the field
    wr(cst_pkg::OFF_INTCTL, 32'h0000_8000);
    wr(cst_pkg::OFF_STATUS, 32'h0000_00a0);
    rd(cst_pkg::OFF_STATUS, 32'h0000_0060, "level frozen");
    sn(6'h03, "level frozen port");
    wr(cst_pkg::OFF_INTCTL, 32'h0000_0000);
    repeat_busy_i <= 1'b1;
    @(posedge mclk_i);
    rd(cst_pkg::OFF_STATUS, 32'h0000_0070, "repeat busy");
    repeat_busy_i <= 1'b0;
    @(posedge mclk_i);
    rd(cst_pkg::OFF_STATUS, 32'h0000_0060, "repeat idle");
    $display("test nesting repeat done");
    // Clip stickies, events, interrupt
    wr(cst_pkg::OFF_EV_CLR, 32'h0000_0007);
    wr(cst_pkg::OFF_EV_EN, 32'h0000_0007);
    clip_a_i <= 1'b1;
    @(posedge mclk_i);
    clip_a_i <= 1'b0;
    rd(cst_pkg::OFF_STATUS, 32'h0000_2460, "clip a sticky");
    rd(cst_pkg::OFF_EV_STAT, 32'h0000_0001, "clip a event");
    sn(6'h23, "irq raised");
    wr(cst_pkg::OFF_STATUS, 32'h0000_2060);
    rd(cst_pkg::OFF_STATUS, 32'h0000_0060, "combined clear");
    wr(cst_pkg::OFF_STATUS, 32'h0000_3460);
    rd(cst_pkg::OFF_STATUS, 32'h0000_3460, "direct write");
    wr(cst_pkg::OFF_EV_CLR, 32'h0000_0001);
    sn(6'h03, "irq cleared");
    wr(cst_pkg::OFF_EV_EN, 32'h0000_0000);
    clip_b_i <= 1'b1;
    @(posedge mclk_i);
    clip_b_i <= 1'b0;
    rd(cst_pkg::OFF_EV_STAT, 32'h0000_0002, "clip b event");
    sn(6'h03, "irq masked");
    wr(cst_pkg::OFF_EV_EN, 32'h0000_0002);
    sn(6'h23, "irq unmasked");
    rd(cst_pkg::OFF_EV_CLR, 32'h0, "clear reads zero");
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0, "unmapped");
    $display("test clip irq done");
    repeat (3) @(posedge mclk_i);
    if (exp_q.size() != 0)
      fail_count++;
    close_out();
  end
endmodule
